// File: hdl/power_save_clock_gating.sv
// Power-save controller: standby modes, clock gating and bus pin states
`timescale 1ns/1ns
`default_nettype none
module power_save_clock_gating
  import psave_pkg::*;
#(
  parameter int STAB_SHORT = STAB_SHORT_CYCLES,
  parameter int STAB_LONG = STAB_LONG_CYCLES
) (
  input wire logic CORE_CLK_IN,              // 25 MHz core clock
  input wire logic RESET_N_IN,               // Async reset, low
  // AHB-Lite slave
  input wire logic HSEL_IN,                  // Slave select
  input wire logic [31:0] HADDR_IN,          // Address
  input wire logic [1:0] HTRANS_IN,          // Transfer type
  input wire logic HWRITE_IN,                // Write
  input wire logic [2:0] HSIZE_IN,           // Size
  input wire logic [31:0] HWDATA_IN,         // Write data
  input wire logic HREADY_IN,                // Bus ready
  output logic [31:0] HRDATA_OUT,            // Read data
  output logic HREADYOUT_OUT,                // Slave ready
  output logic HRESP_OUT,                    // Always OKAY
  // CPU and interrupt side
  input wire logic HALT_EXEC_IN,             // Halt instruction pulse
  input wire logic PREFETCH_FULL_IN,         // Prefetch queue full
  input wire logic INT_REQ_IN,               // Unmasked maskable request
  input wire logic INT_HIGHER_IN,            // Request outranks one in service
  input wire logic INT_ENABLE_IN,            // Interrupts enabled
  input wire logic NMI_SERVICE_IN,           // NMI service in progress
  input wire logic NMI_PIN_IN,               // NMI pin, rising valid
  input wire logic DIRECT_MODE_PIN_IN,       // Direct clock mode strap
  input wire logic BUS_HOLD_REQUEST_IN,      // External hold request
  input wire logic BUS_HOLD_ACKNOWLEDGE_IN,  // Hold granted
  output logic BUS_HOLD_REQ_GATED_OUT,       // Hold request to bus unit
  output logic WAKE_ACK_OUT,                 // Release, take the request
  output logic WAKE_PEND_OUT,                // Release, request held pending
  output logic NMI_EVENT_OUT,                // Valid NMI edge, normal mode
  output clk_gate_type CLK_GATES_OUT,        // Clock enables
  output pin_ctrl_type PIN_CTRL_OUT,         // Expansion pin control
  output logic [2:0] MODE_OUT                // Current mode code
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] sync_reg [2];
  logic [1:0] pin_raw;
  logic [1:0] pin_reg;

  assign pin_raw = {DIRECT_MODE_PIN_IN, NMI_PIN_IN};

  // Three stages; a change counts once stages two and three agree
  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          sync_reg[i] <= 3'h0;
          pin_reg[i] <= 1'b0;
        end else begin
          sync_reg[i] <= {sync_reg[i][1:0], pin_raw[i]};
          if (sync_reg[i][1] == sync_reg[i][2]) begin
            pin_reg[i] <= sync_reg[i][2];
          end
        end
      end
    end
  endgenerate

  logic nmi_prev_reg;
  logic nmi_edge;

  // NMI edge from the filtered level only
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      nmi_prev_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= pin_reg[0];
    end
  end

  assign nmi_edge = pin_reg[0] & ~nmi_prev_reg;

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states

  logic wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic addr_phase;

  function automatic logic is_mapped(input logic [31:0] a);
    return (a == CTRL_ADDR) || (a == STATUS_ADDR) ||
           (a == PROTECT_ADDR);
  endfunction

  assign addr_phase = HSEL_IN & HREADY_IN & HTRANS_IN[1];

  // Capture write address, prepare read data
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
    end else if (HREADY_IN) begin
      wr_pend_reg <= addr_phase & HWRITE_IN;
      wr_addr_reg <= HADDR_IN;
    end
  end

  logic [7:0] ctrl_reg;
  logic err_reg;
  mode_type mode_reg;
  logic [31:0] status_word;

  assign status_word = {26'h0000000, pin_reg[1], err_reg,
                        1'b0, 3'(mode_reg)};

  // Unmapped addresses read zero
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rdata_reg <= 32'h00000000;
    end else if (addr_phase & ~HWRITE_IN) begin
      if (HADDR_IN == CTRL_ADDR) begin
        rdata_reg <= {24'h000000, ctrl_reg};
      end else if (HADDR_IN == STATUS_ADDR) begin
        rdata_reg <= status_word;
      end else begin
        rdata_reg <= 32'h00000000;
      end
    end
  end

  assign HRDATA_OUT = rdata_reg;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = 1'b0;

  logic wr_ctrl;
  logic wr_prot;
  logic wr_stat;

  assign wr_ctrl = wr_pend_reg & (wr_addr_reg == CTRL_ADDR);
  assign wr_prot = wr_pend_reg & (wr_addr_reg == PROTECT_ADDR);
  assign wr_stat = wr_pend_reg & (wr_addr_reg == STATUS_ADDR);

  ////////////////////////////////////////////////////////////////////
  // Protected write sequence

  logic armed_reg;
  logic ctrl_ok;

  // Any access other than a protect write drops the key, the control write included
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      armed_reg <= 1'b0;
    end else if (wr_prot) begin
      armed_reg <= 1'b1;
    end else if (wr_pend_reg | (addr_phase & ~HWRITE_IN)) begin
      armed_reg <= 1'b0;
    end
  end

  assign ctrl_ok = wr_ctrl & armed_reg;

  // Sticky error; a new error wins over a write-one clear
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      err_reg <= 1'b0;
    end else if (wr_ctrl & ~armed_reg) begin
      err_reg <= 1'b1;
    end else if (wr_stat & HWDATA_IN[STAT_ERR_BIT]) begin
      err_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Mode machine

  mode_type mode_next;
  logic stab_start;
  logic stab_busy;
  logic stab_done;
  logic ext_clock;
  logic idle_req;
  logic stop_req;
  logic release_ev;

  // Oscillator bypassed with an external or direct clock
  assign ext_clock = ctrl_reg[CLK_SRC_BIT] | pin_reg[1];

  // Requests carried by an accepted write; stop takes precedence
  assign stop_req = ctrl_ok & HWDATA_IN[STOP_BIT];
  assign idle_req = ctrl_ok & HWDATA_IN[IDLE_BIT];

  // Release from standby: any return to normal mode, from stabilisation too
  assign release_ev = (mode_reg != MODE_NORMAL) &&
                      (mode_next == MODE_NORMAL);

  always_comb begin
    mode_next = mode_reg;
    stab_start = 1'b0;
    unique case (mode_reg)
      MODE_NORMAL: begin
        if (stop_req) begin
          mode_next = MODE_STOP;
        end else if (idle_req) begin
          mode_next = MODE_IDLE;
        end else if (HALT_EXEC_IN) begin
          mode_next = MODE_HALT_FILL;
        end
      end
      MODE_HALT_FILL: begin
        // Wakes here too, before the bus has parked
        if (nmi_edge | INT_REQ_IN) begin
          mode_next = MODE_NORMAL;
        end else if (PREFETCH_FULL_IN) begin
          mode_next = MODE_HALT;
        end
      end
      MODE_HALT: begin
        if (nmi_edge | INT_REQ_IN) begin
          mode_next = MODE_NORMAL;
        end
      end
      MODE_IDLE: begin
        // Maskable requests are not looked at
        if (nmi_edge) begin
          mode_next = MODE_NORMAL;
        end
      end
      MODE_STOP: begin
        if (nmi_edge) begin
          if (ext_clock) begin
            mode_next = MODE_NORMAL;
          end else begin
            mode_next = MODE_STAB;
            stab_start = 1'b1;
          end
        end
      end
      MODE_STAB: begin
        if (stab_done) begin
          mode_next = MODE_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode_reg <= MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign MODE_OUT = 3'(mode_reg);

  ////////////////////////////////////////////////////////////////////
  // Control register

  // Request bits self-clear on release
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_ok) begin
      ctrl_reg <= HWDATA_IN[7:0] & CTRL_WMASK;
    end else if (release_ev) begin
      ctrl_reg[IDLE_BIT] <= 1'b0;
      ctrl_reg[STOP_BIT] <= 1'b0;
    end
  end

  // Time base: count length picked by the select bit
  stab_counter #(
    .SHORT_CYCLES(STAB_SHORT),
    .LONG_CYCLES(STAB_LONG)
  ) u_stab (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .start_in(stab_start),
    .sel_in(ctrl_reg[STAB_SEL_BIT]),
    .busy_out(stab_busy),
    .done_out(stab_done)
  );

  ////////////////////////////////////////////////////////////////////
  // Wake acknowledge or pend

  logic ack_reg;
  logic pend_reg;
  logic nmi_ev_reg;
  logic nmi_in_idle_reg;

  // Remember whether standby began inside NMI service
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      nmi_in_idle_reg <= 1'b0;
    end else if (mode_reg == MODE_NORMAL) begin
      nmi_in_idle_reg <= NMI_SERVICE_IN;
    end
  end

  // One pulse per release; lower priority or masked-off requests pend
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ack_reg <= 1'b0;
      pend_reg <= 1'b0;
      nmi_ev_reg <= 1'b0;
    end else begin
      ack_reg <= 1'b0;
      pend_reg <= 1'b0;
      nmi_ev_reg <= nmi_edge & (mode_reg == MODE_NORMAL);
      if (release_ev) begin
        if (mode_reg == MODE_HALT || mode_reg == MODE_HALT_FILL) begin
          if (nmi_edge) begin
            ack_reg <= 1'b1;
          end else if (INT_HIGHER_IN & INT_ENABLE_IN) begin
            ack_reg <= 1'b1;
          end else begin
            pend_reg <= 1'b1;
          end
        end else if (nmi_in_idle_reg) begin
          pend_reg <= 1'b1;
        end else begin
          ack_reg <= 1'b1;
        end
      end
    end
  end

  assign WAKE_ACK_OUT = ack_reg;
  assign WAKE_PEND_OUT = pend_reg;
  assign NMI_EVENT_OUT = nmi_ev_reg;

  ////////////////////////////////////////////////////////////////////
  // Clock gating and pin states

  clk_gate_type gates_reg;
  pin_ctrl_type pins_reg;
  logic in_halt;
  logic stopped;

  assign in_halt = (mode_next == MODE_HALT_FILL) ||
                   (mode_next == MODE_HALT);
  assign stopped = (mode_next == MODE_STOP) ||
                   (mode_next == MODE_STAB);

  // Registered enables follow the next mode
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      // Clock output starts inhibited, matching the control reset value
      gates_reg <= '{cpu: 1'b1, sys: 1'b1, osc: 1'b1,
                     pll: 1'b1, clk_out: 1'b0};
    end else begin
      gates_reg.cpu <= (mode_next == MODE_NORMAL);
      gates_reg.sys <= (mode_next == MODE_NORMAL) | in_halt;
      // Oscillator idles when bypassed; PLL dies with it in stop
      gates_reg.osc <= ~stopped & ~ext_clock;
      gates_reg.pll <= ~stopped & ~pin_reg[1];
      gates_reg.clk_out <= ((mode_next == MODE_NORMAL) | in_halt) &
                           (ctrl_reg[CLK_OUT_HI_BIT:CLK_OUT_LO_BIT]
                            != CLK_OUT_INHIBIT);
    end
  end

  assign CLK_GATES_OUT = gates_reg;

  // Parked pins only once the prefetch queue has filled
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pins_reg <= '{ad_oe: 1'b1, addr_oe: 1'b1, addr_hold: 1'b0,
                    ctl_force_high: 1'b0, ctl_oe: 1'b1,
                    hold_ack_oe: 1'b1};
    end else if (mode_next == MODE_HALT) begin
      pins_reg.ad_oe <= 1'b0;
      pins_reg.addr_hold <= 1'b1;
      pins_reg.addr_oe <= ~BUS_HOLD_ACKNOWLEDGE_IN;
      pins_reg.ctl_force_high <= 1'b1;
      pins_reg.ctl_oe <= ~BUS_HOLD_ACKNOWLEDGE_IN;
      pins_reg.hold_ack_oe <= 1'b1;
    end else if (mode_next == MODE_NORMAL ||
                 mode_next == MODE_HALT_FILL) begin
      pins_reg.ad_oe <= 1'b1;
      pins_reg.addr_hold <= 1'b0;
      pins_reg.addr_oe <= 1'b1;
      pins_reg.ctl_force_high <= 1'b0;
      pins_reg.ctl_oe <= 1'b1;
      pins_reg.hold_ack_oe <= 1'b1;
    end else begin
      pins_reg <= '{default: 1'b0};
    end
  end

  assign PIN_CTRL_OUT = pins_reg;

  // Hold requests blocked outside normal and halt
  assign BUS_HOLD_REQ_GATED_OUT = BUS_HOLD_REQUEST_IN &
      (gates_reg.sys) & ~stab_busy;

endmodule // power_save_clock_gating
`default_nettype wire

// File: hdl/psave_pkg.sv
// Package: register map, field layout and carrier types of the power-save controller
package psave_pkg;
  // Register byte addresses
  localparam logic [31:0] CTRL_ADDR = 32'hFFFFF070;
  localparam logic [31:0] STATUS_ADDR = 32'hFFFFF074;
  localparam logic [31:0] PROTECT_ADDR = 32'hFFFFF07C;
  // power_save_control fields
  localparam int CLK_OUT_HI_BIT = 7;
  localparam int CLK_OUT_LO_BIT = 6;
  localparam int STAB_SEL_BIT = 5;
  localparam int CLK_SRC_BIT = 4;
  localparam int IDLE_BIT = 2;
  localparam int STOP_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'hC0;
  localparam logic [7:0] CTRL_WMASK = 8'hF6;
  localparam logic [1:0] CLK_OUT_INHIBIT = 2'h3;
  // Status register fields
  localparam int STAT_ERR_BIT = 4;
  localparam int STAT_DIRECT_BIT = 5;
  // Stabilisation counts, in core clock cycles
  localparam int STAB_SHORT_CYCLES = 8192;
  localparam int STAB_LONG_CYCLES = 65536;
  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_HALT_FILL,
    MODE_HALT,
    MODE_IDLE,
    MODE_STOP,
    MODE_STAB
  } mode_type;
  // Clock enables leaving the block
  typedef struct packed {
    logic cpu;
    logic sys;
    logic osc;
    logic pll;
    logic clk_out;
  } clk_gate_type;
  // External expansion bus pin control
  typedef struct packed {
    logic ad_oe;
    logic addr_oe;
    logic addr_hold;
    logic ctl_force_high;
    logic ctl_oe;
    logic hold_ack_oe;
  } pin_ctrl_type;
endpackage

// File: hdl/stab_counter.sv
// Oscillator stabilisation counter used after stop release
`timescale 1ns/1ns
`default_nettype none
module stab_counter #(
  parameter int SHORT_CYCLES = 8192,
  parameter int LONG_CYCLES = 65536
) (
  input wire logic clk_in,    // Core clock
  input wire logic rst_n_in,  // Async reset, low
  input wire logic start_in,  // Start pulse
  input wire logic sel_in,    // Long count when high
  output logic busy_out,      // Counting
  output logic done_out       // One-cycle end pulse
);
  logic [16:0] count_reg;
  logic busy_reg;
  logic done_reg;

  // Load on start, count down to one then flag done
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= 17'h00000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start_in) begin
        count_reg <= sel_in ? 17'(LONG_CYCLES) : 17'(SHORT_CYCLES);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (count_reg <= 17'h00001) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          count_reg <= count_reg - 17'h00001;
        end
      end
    end
  end

  assign busy_out = busy_reg;
  assign done_out = done_reg;
endmodule // stab_counter
`default_nettype wire

// File: testbench/psave_properties.sv
// Checker: port properties of the power-save controller
`timescale 1ns/1ns
`default_nettype none
module psave_properties
  import psave_pkg::*;
#(
  parameter int STAB_SHORT = 4,
  parameter int STAB_LONG = 8
) (
  input wire logic CORE_CLK_IN,             // Clock
  input wire logic RESET_N_IN,              // Reset, low
  input wire logic HREADYOUT_OUT,           // Ready
  input wire logic HRESP_OUT,               // Response
  input wire logic HALT_EXEC_IN,            // Halt pulse
  input wire logic PREFETCH_FULL_IN,        // Queue full
  input wire logic INT_REQ_IN,              // Maskable request
  input wire logic BUS_HOLD_ACKNOWLEDGE_IN, // Hold granted
  input wire logic BUS_HOLD_REQ_GATED_OUT,  // Gated hold
  input wire clk_gate_type CLK_GATES_OUT,   // Clock enables
  input wire pin_ctrl_type PIN_CTRL_OUT,    // Pin control
  input wire logic [2:0] MODE_OUT           // Mode
);
  int stab_cnt;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  ////////////////////////////////////////////////////////////
  // Length of the current stabilisation run
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      stab_cnt <= 0;
    end else if (MODE_OUT == 3'h5) begin
      stab_cnt <= stab_cnt + 1;
    end else begin
      stab_cnt <= 0;
    end
  end
  ////////////////////////////////////////////////////////////
  halt_entry_a: assert property (MODE_OUT == 3'h0 && HALT_EXEC_IN |=> MODE_OUT == 3'h1)
    else $error("halt pulse not taken");
  fill_done_a: assert property (MODE_OUT == 3'h1 && !INT_REQ_IN
    |=> MODE_OUT == ($past(PREFETCH_FULL_IN) ? 3'h2 : 3'h1)) else $error("fill step wrong");
  halt_gates_a: assert property (MODE_OUT == 3'h2 [*2] |-> !CLK_GATES_OUT.cpu && CLK_GATES_OUT.sys)
    else $error("halt gates wrong");
  halt_pins_a: assert property (MODE_OUT == 3'h2 [*2] |-> PIN_CTRL_OUT ==
    {1'b0, !$past(BUS_HOLD_ACKNOWLEDGE_IN), 2'h3, !$past(BUS_HOLD_ACKNOWLEDGE_IN), 1'b1})
    else $error("halt pins wrong");
  idle_state_a: assert property (MODE_OUT == 3'h3 [*2]
    |-> CLK_GATES_OUT == 5'h6 && PIN_CTRL_OUT == 6'h0) else $error("idle gates or pins wrong");
  stop_state_a: assert property (MODE_OUT == 3'h4 [*2]
    |-> CLK_GATES_OUT == 5'h0 && PIN_CTRL_OUT == 6'h0) else $error("stop gates or pins wrong");
  idle_hold_a: assert property (MODE_OUT == 3'h3 [*2] |-> !BUS_HOLD_REQ_GATED_OUT)
    else $error("hold passed in idle");
  idle_exit_a: assert property (MODE_OUT == 3'h3 |=> MODE_OUT inside {3'h0, 3'h3})
    else $error("idle left wrongly");
  halt_wake_a: assert property (MODE_OUT == 3'h2 && INT_REQ_IN |-> ##[1:3] MODE_OUT == 3'h0)
    else $error("interrupt did not end halt");
  stab_len_a: assert property (MODE_OUT == 3'h5 |-> stab_cnt <= STAB_LONG)
    else $error("stabilisation too long");
  bus_okay_a: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus answer not okay");
  cover property (MODE_OUT == 3'h2 [*2]);
  cover property (MODE_OUT == 3'h3 [*2]);
  cover property (stab_cnt == STAB_SHORT);
endmodule // psave_properties
bind power_save_clock_gating psave_properties #(.STAB_SHORT(STAB_SHORT), .STAB_LONG(STAB_LONG)) i_props (
  .CORE_CLK_IN, .RESET_N_IN, .HREADYOUT_OUT, .HRESP_OUT, .HALT_EXEC_IN, .PREFETCH_FULL_IN,
  .INT_REQ_IN, .BUS_HOLD_ACKNOWLEDGE_IN, .BUS_HOLD_REQ_GATED_OUT, .CLK_GATES_OUT,
  .PIN_CTRL_OUT, .MODE_OUT);
`default_nettype wire

// File: testbench/cpu_model.sv
// Partner: CPU prefetch queue that fills some cycles after a halt
`timescale 1ns/1ns
`default_nettype none
module cpu_model (
  input wire logic clk_in,          // Clock
  input wire logic rst_n_in,        // Reset, low
  input wire logic halt_in,         // Halt executed
  input wire logic [3:0] delay_in,  // Fill delay
  output logic full_out             // Queue full
);
  logic [3:0] cnt_reg;
  // Queue drains on halt, then refills after a variable fetch time
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg <= 4'h0;
      full_out <= 1'b1;
    end else if (halt_in) begin
      cnt_reg <= delay_in;
      full_out <= 1'b0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      full_out <= 1'b1;
    end
  end
endmodule // cpu_model
`default_nettype wire

// File: testbench/power_save_clock_gating_tb.sv
// Testbench: registers, standby entry and release of the power-save controller
`timescale 1ns/1ns
`default_nettype none
module power_save_clock_gating_tb;
  import psave_pkg::*;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, halt, full, int_req, int_hi, int_en, nmi_svc, nmi;
  logic direct, hold_req, hold_ack, gated, wake_ack, wake_pend, nmi_ev;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic [2:0] hsize, mode;
  logic [3:0] delay;
  logic [7:0] ctrl_m;
  clk_gate_type gates;
  pin_ctrl_type pins;
  int failures, total_checks, cyc, ack_cnt, pend_cnt, ev_cnt, stab_seen, ea, ep, seed;
  logic [7:0] stop_v [4] = '{8'h02, 8'h22, 8'h12, 8'h06};
  // Stabilisation holds the count plus the cycle that sees the done pulse
  int stop_n [4] = '{5, 9, 0, 5};
  ////////////////////////////////////////////////////////////
  power_save_clock_gating #(.STAB_SHORT(4), .STAB_LONG(8)) i_dut (
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hreadyout),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .HALT_EXEC_IN(halt),
    .PREFETCH_FULL_IN(full), .INT_REQ_IN(int_req), .INT_HIGHER_IN(int_hi), .INT_ENABLE_IN(int_en),
    .NMI_SERVICE_IN(nmi_svc), .NMI_PIN_IN(nmi), .DIRECT_MODE_PIN_IN(direct),
    .BUS_HOLD_REQUEST_IN(hold_req), .BUS_HOLD_ACKNOWLEDGE_IN(hold_ack), .BUS_HOLD_REQ_GATED_OUT(gated),
    .WAKE_ACK_OUT(wake_ack), .WAKE_PEND_OUT(wake_pend), .NMI_EVENT_OUT(nmi_ev),
    .CLK_GATES_OUT(gates), .PIN_CTRL_OUT(pins), .MODE_OUT(mode));
  cpu_model i_cpu (.clk_in(clk), .rst_n_in(rst_n), .halt_in(halt), .delay_in(delay), .full_out(full));
  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Release pulses, stabilisation length and hang guard
  always @(posedge clk) begin
    if (wake_ack === 1'b1) ack_cnt++;
    if (wake_pend === 1'b1) pend_cnt++;
    if (nmi_ev === 1'b1) ev_cnt++;
    if (mode === 3'h5) stab_seen++;
    cyc++;
    if (cyc > 6000) begin
      failures++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single transfer: address phase, then data phase
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  // Idle cycle after a write so a following read sees the new value
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
    @(posedge clk);
  endtask
  task automatic pw(input logic [7:0] d);
    wr(PROTECT_ADDR, 32'h0);
    wr(CTRL_ADDR, {24'h0, d});
    ctrl_m = d & CTRL_WMASK;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk("rdata", rdat, e);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("mode", {29'h0, mode}, {29'h0, m});
  endtask
  // Expected enables per mode, external source stops the oscillator
  function automatic logic [4:0] exp_gates(input int m);
    return {m == 0, m <= 2, m < 4 && !ctrl_m[CLK_SRC_BIT], m < 4,
            m <= 2 && ctrl_m[7:6] != CLK_OUT_INHIBIT};
  endfunction
  task automatic chkg(input int m);
    repeat (2) @(posedge clk);
    chk("gates", {27'h0, gates}, {27'h0, exp_gates(m)});
  endtask
  task automatic nmi_pulse();
    nmi <= 1'b1;
    wait_mode(3'h0);
    nmi <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ack", ack_cnt, ea);
    chk("pend", pend_cnt, ep);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, halt, int_req, int_en, nmi_svc, nmi, direct, hold_req, hold_ack, hwrite} = '0;
    {hsel, int_hi} = 2'h3;
    {haddr, hwdata, htrans, hsize, delay, ea, ep, stab_seen} = '0;
    {failures, total_checks, cyc, ack_cnt, pend_cnt, ev_cnt} = '0;
    seed = 45;
    ctrl_m = CTRL_RESET;
    hsize = 3'h2;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rdc(CTRL_ADDR, 32'hC0);
    chkg(0);
    rdc(32'hFFFFF0F0, 32'h0);
    wr(CTRL_ADDR, 32'h0);
    rdc(CTRL_ADDR, 32'hC0);
    rdc(STATUS_ADDR, 32'h10);
    wr(PROTECT_ADDR, 32'h0);
    rdc(PROTECT_ADDR, 32'h0);
    wr(CTRL_ADDR, 32'h0);
    rdc(CTRL_ADDR, 32'hC0);
    for (int i = 0; i < 4; i++) begin
      pw(8'($random(seed)) & 8'h30 | 8'(i << 6));
      rdc(CTRL_ADDR, {24'h0, ctrl_m});
      chkg(0);
    end
    pw(8'h00);
    for (int k = 0; k < 3; k++) begin
      delay <= 4'($random(seed)) | 4'h1;
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      wait_mode(3'h1);
      wait_mode(3'h2);
      chkg(2);
      chk("pins", {26'h0, pins}, 32'h1F);
      hold_ack <= 1'b1;
      repeat (2) @(posedge clk);
      chk("pins", {26'h0, pins}, 32'h0D);
      hold_ack <= 1'b0;
      if (k == 1) ep++;
      else ea++;
      if (k == 2) begin
        nmi_pulse();
      end else begin
        int_hi <= (k == 0);
        int_en <= 1'b1;
        int_req <= 1'b1;
        wait_mode(3'h0);
        int_req <= 1'b0;
        int_hi <= 1'b1;
        repeat (4) @(posedge clk);
        chk("ack", ack_cnt, ea);
        chk("pend", pend_cnt, ep);
      end
    end
    for (int s = 0; s < 2; s++) begin
      hold_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk("hold", {31'h0, gated}, 32'h1);
      nmi_svc <= s[0];
      pw(8'h04);
      wait_mode(3'h3);
      chkg(3);
      chk("pins", {26'h0, pins}, 32'h0);
      int_req <= 1'b1;
      repeat (4) @(posedge clk);
      chk("mode", {29'h0, mode}, 32'h3);
      chk("hold", {31'h0, gated}, 32'h0);
      {int_req, hold_req} <= 2'h0;
      if (s == 1) ep++;
      else ea++;
      nmi_pulse();
      nmi_svc <= 1'b0;
      ctrl_m[IDLE_BIT] = 1'b0;
      rdc(CTRL_ADDR, {24'h0, ctrl_m});
    end
    for (int j = 0; j < 4; j++) begin
      pw(stop_v[j]);
      wait_mode(3'h4);
      chkg(4);
      stab_seen = 0;
      ea++;
      nmi_pulse();
      chk("stab", stab_seen, stop_n[j]);
      ctrl_m = ctrl_m & 8'hF9;
      rdc(CTRL_ADDR, {24'h0, ctrl_m});
      chkg(0);
    end
    // NMI edge in normal mode is reported once and releases nothing
    nmi <= 1'b1;
    repeat (8) @(posedge clk);
    nmi <= 1'b0;
    chk("nmi_ev", ev_cnt, 1);
    chk("ack", ack_cnt, ea);
    // Direct strap: source parks its clock low while stopped, no PLL, no wait
    direct <= 1'b1;
    repeat (6) @(posedge clk);
    rdc(STATUS_ADDR, 32'h30);
    chk("gates", {27'h0, gates}, 32'h19);
    wr(STATUS_ADDR, 32'h10);
    rdc(STATUS_ADDR, 32'h20);
    pw(8'h02);
    wait_mode(3'h4);
    stab_seen = 0;
    ea++;
    nmi_pulse();
    chk("stab", stab_seen, 0);
    end_sim();
  end
endmodule // power_save_clock_gating_tb
`default_nettype wire
